// file: inc/eirq_pkg.sv
// Package for the external request latch: option layout, timing, states.
// Assumes a 50 MHz core clock.
package eirq_pkg;
	localparam int CLK_MHZ = 50;
	// Least low time on the request pin, in ns
	localparam int MIN_REQUEST_LOW_TIME_NS = 100;
	localparam int MIN_LOW_CYC_RAW = (MIN_REQUEST_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int MIN_LOW_CYCLES = (MIN_LOW_CYC_RAW < 1) ? 1 : MIN_LOW_CYC_RAW;
	localparam int CNT_W = 8;
	// Option store: five bits holding four options
	localparam int OPT_W = 5;
	localparam int OPT_STOP_EN_BIT = 0;
	localparam int OPT_LEVEL_BIT = 1;
	localparam int OPT_WDOG_EN_BIT = 2;
	localparam int OPT_RATE_LSB = 3;
	localparam int OPT_RATE_W = 2;
	localparam logic [OPT_W-1:0] OPT_RESET_VAL = 5'h00;
	localparam logic [CNT_W-1:0] CNT_RESET_VAL = 8'h00;

	typedef enum logic [1:0] {EIRQ_RUN, EIRQ_ENTRY} eirq_state_t;
endpackage : eirq_pkg

// file: inc/eirq_opt_if.sv
// Carries the decoded option store fields between the latch and the store.
`timescale 1ns/100ps
interface eirq_opt_if;
	logic level_sense;
	logic stop_en;
	logic wdog_en;
	logic [1:0] rate;
	modport store (output level_sense, output stop_en, output wdog_en, output rate);
	modport user (input level_sense, input stop_en, input wdog_en, input rate);
endinterface : eirq_opt_if

// file: logic/eirq_opt_store.sv
// Option store: holds the five nonvolatile bits, resampled on every clock outside reset.
// Assumes the nonvolatile cells present a steady value on opt_bits_i.
`timescale 1ns/100ps
module eirq_opt_store
	import eirq_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Raw cells
	input wire logic [OPT_W-1:0] opt_bits_i,
	// Decoded options
	eirq_opt_if.store opt
);
	typedef struct packed {
		logic [OPT_W-1:0] bits;
	} eirq_store_st_t;
	eirq_store_st_t s_q, s_d;

	always_comb
	begin
		s_d = s_q;
		// Cells sampled by the clock, never by the reset itself
		if (!rst_i)
			s_d.bits = opt_bits_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s_q <= '{bits: OPT_RESET_VAL};
		else
			s_q <= s_d;
	end

	assign opt.stop_en = s_q.bits[OPT_STOP_EN_BIT];
	assign opt.level_sense = s_q.bits[OPT_LEVEL_BIT];
	assign opt.wdog_en = s_q.bits[OPT_WDOG_EN_BIT];
	assign opt.rate = s_q.bits[OPT_RATE_LSB +: OPT_RATE_W];
endmodule : eirq_opt_store

// file: logic/eirq_latch.sv
// External interrupt request latch with edge or edge-and-level sensing.
// Assumes core gives instruction-done pulses and the mask flag on clk_i.
`timescale 1ns/100ps
// Functional notes
// - Pin low long enough sets request latch
// - Latch tested only at instruction completion
// - Pending and unmasked starts interrupt entry
// - Sensitivity: falling edge, or edge plus level
// - Options come from five-bit option store
// - Reset returns logic to known state
module eirq_latch
	import eirq_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Request pin, active low
	input wire logic req_n_i,
	// Option store cells
	input wire logic [OPT_W-1:0] opt_bits_i,
	// Core handshake
	input wire logic instr_done_i,
	input wire logic irq_mask_i,
	// Results
	output logic pending_o,
	output logic entry_o,
	output logic stop_en_o,
	output logic wdog_en_o,
	output logic [1:0] rate_o
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic low_q;
		logic armed;
		logic [CNT_W-1:0] low_cnt;
		logic pending;
		logic entry;
		logic stop_en;
		logic wdog_en;
		logic [1:0] rate;
		eirq_state_t st;
	} eirq_st_t;
	eirq_st_t s_q, s_d;
	eirq_opt_if opt ();

	eirq_opt_store u_store (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.opt_bits_i(opt_bits_i),
		.opt(opt)
	);

	always_comb
	begin
		logic qualified;
		logic take;
		qualified = 1'b0;
		take = 1'b0;
		s_d = s_q;
		s_d.sync1 = req_n_i;
		s_d.sync2 = s_q.sync1;
		s_d.entry = 1'b0;
		// Low-time filter rejects glitches shorter than the minimum
		if (s_q.sync2)
		begin
			s_d.low_cnt = CNT_RESET_VAL;
			s_d.low_q = 1'b0;
			s_d.armed = 1'b1;
		end
		else if (s_q.low_cnt < CNT_W'(MIN_LOW_CYCLES - 1))
			s_d.low_cnt = s_q.low_cnt + 1'b1;
		else
			s_d.low_q = 1'b1;
		if (s_d.low_q && !s_q.low_q && s_q.armed)
		begin
			qualified = 1'b1;
			s_d.armed = 1'b0;
		end
		// Level mode keeps requesting while the line stays low
		if (opt.level_sense && s_q.low_q)
			qualified = 1'b1;
		case (s_q.st)
			EIRQ_RUN:
			begin
				if (instr_done_i && s_q.pending && !irq_mask_i)
					take = 1'b1;
			end
			EIRQ_ENTRY:
				s_d.st = EIRQ_RUN;
			default:
				s_d.st = EIRQ_RUN;
		endcase
		if (take)
		begin
			s_d.entry = 1'b1;
			s_d.st = EIRQ_ENTRY;
		end
		// A new request in the take cycle survives the clear
		if (qualified)
			s_d.pending = 1'b1;
		else if (take)
			s_d.pending = 1'b0;
		s_d.stop_en = opt.stop_en;
		s_d.wdog_en = opt.wdog_en;
		s_d.rate = opt.rate;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_q <= '{sync1: 1'b1, sync2: 1'b1, low_q: 1'b0, armed: 1'b0,
				low_cnt: CNT_RESET_VAL, pending: 1'b0, entry: 1'b0,
				stop_en: 1'b0, wdog_en: 1'b0, rate: 2'h0, st: EIRQ_RUN};
		end
		else
			s_q <= s_d;
	end

	assign pending_o = s_q.pending;
	assign entry_o = s_q.entry;
	assign stop_en_o = s_q.stop_en;
	assign wdog_en_o = s_q.wdog_en;
	assign rate_o = s_q.rate;
endmodule : eirq_latch

// file: test/eirq_monitor.sv
// Port checker for the request latch.
// Option cells change only in reset.
`timescale 1ns/100ps
module eirq_monitor
	import eirq_pkg::*;
(
	// Inputs
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_n_i,
	input wire logic [OPT_W-1:0] opt_bits_i,
	input wire logic instr_done_i,
	input wire logic irq_mask_i,
	// Outputs
	input wire logic pending_o,
	input wire logic entry_o,
	input wire logic stop_en_o,
	input wire logic wdog_en_o,
	input wire logic [1:0] rate_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A done pulse during the entry cycle itself is ignored by design
	take_now_a: assert property (instr_done_i && pending_o && !irq_mask_i && !entry_o |=> entry_o ##1 !entry_o)
		else $error("no entry");
	entry_cause_a: assert property (entry_o |-> $past(instr_done_i && pending_o && !irq_mask_i))
		else $error("stray entry");
	mask_hold_a: assert property (instr_done_i && irq_mask_i && pending_o |=> !entry_o && pending_o)
		else $error("mask");
	pend_hold_a: assert property (pending_o && !instr_done_i |=> pending_o)
		else $error("lost");
	edge_clr_a: assert property (entry_o && !opt_bits_i[1] |-> !pending_o)
		else $error("not cleared");
	rst_clear_a: assert property (disable iff (1'b0) rst_i |=> !pending_o && !entry_o)
		else $error("reset");
	low_rise_a: assert property ($rose(pending_o) |-> !$past(req_n_i, 5))
		else $error("rise");
	// Option outputs lag the cells by two edges, so skip the edges just after reset
	opt_copy_a: assert property ($stable(opt_bits_i)[*3] ##0 (!$past(rst_i) && !$past(rst_i, 2)) |->
		{rate_o, wdog_en_o, stop_en_o} == {opt_bits_i[4:2], opt_bits_i[0]})
		else $error("options");
endmodule : eirq_monitor
bind eirq_latch eirq_monitor u_mon (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.req_n_i(req_n_i),
	.opt_bits_i(opt_bits_i),
	.instr_done_i(instr_done_i),
	.irq_mask_i(irq_mask_i),
	.pending_o(pending_o),
	.entry_o(entry_o),
	.stop_en_o(stop_en_o),
	.wdog_en_o(wdog_en_o),
	.rate_o(rate_o)
);

// file: test/eirq_req_src.sv
// Far side: a source pulling the shared request line low.
// A board pull-up holds the line high when released.
`timescale 1ns/100ps
module eirq_req_src
(
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [7:0] len_i,
	output logic req_n_o
);
	logic [7:0] cnt_q = 8'h00;
	always @(posedge clk_i)
		cnt_q <= go_i ? len_i : cnt_q - {7'h00, cnt_q != 8'h00};
	assign req_n_o = (cnt_q == 8'h00); // Released line rises by pull-up
endmodule : eirq_req_src

// file: test/testbench.sv
// Bench: pulses and takes in both sensing modes.
// The source model drives the pin.
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_checks++; if ((e) !== (a)) begin failures++; \
$display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module testbench;
	logic clock_i = 1'b0, rst_i = 1'b1, done = 1'b0, mask = 1'b0, go = 1'b0, req_n, pnd, ent;
	logic [4:0] opt = 5'h00;
	logic [7:0] len = 8'h00;
	logic [1:0] rt;
	logic stp, wdg;
	int failures = 0, n_checks = 0, seed = 32'he881, cyc = 0, pend, lvl;
	always #10 clock_i = ~clock_i;
	eirq_req_src src (.clk_i(clock_i), .go_i(go), .len_i(len), .req_n_o(req_n));
	eirq_latch dut (.clk_i(clock_i), .rst_i(rst_i), .req_n_i(req_n), .opt_bits_i(opt),
		.instr_done_i(done), .irq_mask_i(mask), .pending_o(pnd), .entry_o(ent),
		.stop_en_o(stp), .wdog_en_o(wdg), .rate_o(rt));
	task automatic print_verdict;
		if (failures == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	always @(posedge clock_i)
		if (++cyc == 3000)
		begin
			failures++;
			print_verdict();
		end
	initial
	begin
		for (lvl = 0; lvl < 2; lvl++)
		begin
			@(posedge clock_i) rst_i <= 1'b1;
			opt <= (5'($random(seed)) & 5'h1d) | 5'(lvl << 1);
			repeat (12) @(posedge clock_i);
			rst_i <= 1'b0;
			pend = 0;
			repeat (3) @(posedge clock_i);
			`CHK("options", {opt[4:3], opt[2], opt[0]}, {rt, wdg, stp})
			for (int i = 0; i < 10; i++)
			begin
				len <= $random(seed) & 1 ? 8'h14 : 8'h02 + 8'($random(seed) & 1);
				go <= 1'b1;
				@(posedge clock_i) go <= 1'b0;
				repeat (14) @(posedge clock_i);
				if (len == 8'h14)
					pend = 1;
				`CHK("pending", 1'(pend), pnd)
				mask <= 1'($random(seed));
				done <= 1'b1;
				@(posedge clock_i) done <= 1'b0;
				#1;
				`CHK("entry", 1'(pend && !mask), ent)
				if (!mask)
					pend = lvl & (len == 8'h14);
				`CHK("after take", 1'(pend), pnd)
				repeat (14) @(posedge clock_i);
			end
		end
		print_verdict();
	end
endmodule : testbench
